//--- common/camera_uart_pkg.sv
// constants for the camera serial port and its interrupt status logic
package camera_uart_pkg;
    // =========================================================
    // register offsets
    localparam logic [7:0] OFS_COMMAND = 8'h00;      // write-only clear pulses
    localparam logic [7:0] OFS_CONFIG = 8'h02;       // acquisition irq enable
    localparam logic [7:0] OFS_UTIL3 = 8'h05;        // edge polarity, expose select
    localparam logic [7:0] OFS_CHAR = 8'h0a;         // camera_serial_char
    localparam logic [7:0] OFS_STATUS = 8'h0b;       // camera_serial_irq_status
    localparam logic [7:0] OFS_CONTROL = 8'h0c;      // serial control
    localparam logic [7:0] OFS_UTIL2 = 8'h10;        // fv irq enable, opto select
    localparam logic [7:0] OFS_EVENTS = 8'h30;       // sticky events, read clears
    localparam logic [7:0] OFS_EVMASK = 8'h31;       // event mask
    // =========================================================
    // field positions
    localparam int CMD_ACQ_CLR = 2;
    localparam int CMD_FV_CLR = 4;
    localparam int CFG_ACQ_EN = 7;
    localparam int U3_POL = 2;
    localparam int U3_EXPOSE = 3;
    localparam int U2_FV_EN = 3;
    localparam int U2_OPTO = 4;
    localparam int CTL_RX_EN = 0;
    localparam int CTL_TX_EN = 1;
    localparam int CTL_RX_IE = 2;
    localparam int CTL_TX_IE = 3;
    localparam int CTL_GLOB_IE = 4;
    localparam int CTL_RX_CLR = 5;
    localparam int CTL_BAUD_LO = 6;
    localparam int ST_RX_RDY = 0;
    localparam int ST_TX_RDY = 1;
    localparam int ST_FV_GATED = 4;
    localparam int ST_ACQ = 5;
    localparam int ST_FV_PEND = 6;
    localparam int ST_INTFC = 7;
    // event bits: 0 rx char, 1 tx done, 2 selected frame-valid irq source edge, 3 acquisition, 4 rx framing error
    localparam int EV_WIDTH = 5;
    // =========================================================
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [EV_WIDTH-1:0] EVMASK_RESET = 5'h00;
    // =========================================================
    // timing: 8 data bits, one stop bit, no parity
    localparam int CLK_HZ = 125_000_000;
    localparam int DATA_BITS = 8;
    localparam int BAUD_0 = 9600;
    localparam int BAUD_1 = 19200;
    localparam int BAUD_2 = 38400;
    localparam int BAUD_3 = 115200;
    localparam int BIT_CYC_0 = CLK_HZ / BAUD_0;
    localparam int BIT_CYC_1 = CLK_HZ / BAUD_1;
    localparam int BIT_CYC_2 = CLK_HZ / BAUD_2;
    localparam int BIT_CYC_3 = CLK_HZ / BAUD_3;
    // =========================================================
    // serial engine states
    typedef enum logic [1:0] {
        LN_IDLE = 2'b00,
        LN_START = 2'b01,
        LN_DATA = 2'b10,
        LN_STOP = 2'b11
    } line_state_e;
endpackage : camera_uart_pkg

//--- verification/camera_serial_model.sv
// behavioural camera end of the serial control line
`timescale 1ns/1ps
module camera_serial_model #(
    parameter int BIT_CYC = 16 // clocks per bit, must match the port
) (
    input wire logic clk_in,  // system clock
    input wire logic line_in, // line from the port
    output logic line_out,    // line towards the port
    output logic [7:0] got_out // last byte heard
);
    // =========================================================
    // transmitter; line is pulled high between characters
    initial line_out = 1'b1; // idle high
    task send(input logic [7:0] b);
        line_out <= 1'b0; // one low start bit
        repeat (BIT_CYC) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            line_out <= b[i]; // eight bits, lsb first
            repeat (BIT_CYC) @(posedge clk_in);
        end
        line_out <= 1'b1; // one stop bit, no parity
        repeat (BIT_CYC) @(posedge clk_in);
    endtask : send
    // =========================================================
    // receiver samples mid-bit so clock skew of a few cycles is harmless
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_in);
            got_out[i] = line_in; // lsb first
        end
        repeat (BIT_CYC) @(posedge clk_in); // skip the stop bit
    end
endmodule : camera_serial_model

//--- verification/camera_uart_irq_status_bench.sv
// self-checking bench for the camera serial port and interrupt status
`timescale 1ns/1ps
module camera_uart_irq_status_bench;
    // =========================================================
    // signals
    logic clk_in = 0, rst_in = 1, wr_s = 0, rd_s = 0; // clock, reset, strobes
    logic [7:0] addr = 0, wdat = 0, rdat, got, v, b; // bus and scratch
    logic [2:0] pins = 0; // {opto, expose, frame-valid}
    logic acq = 0, ser_o, ser_i, irq_req, irq, pol; // pins and irqs
    int bad_count = 0, samples_checked = 0, cyc = 0, sel;
    logic [15:0] bridge_cfg = 16'hc000; // host bridge model: bus and remote enables
    wire host_irq = irq_req && bridge_cfg[15] && bridge_cfg[14];
    always #4 clk_in = ~clk_in; // 125 MHz
    camera_uart_irq_status #(.BIT_CYC_0(16), .BIT_CYC_1(12), .BIT_CYC_2(8), .BIT_CYC_3(4))
        i_camera_uart_irq_status (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdat),
        .serial_in_from_camera(ser_i), .serial_out_to_camera(ser_o),
        .frame_valid_in(pins[0]), .expose_in(pins[1]), .opto_trigger_in(pins[2]),
        .acquire_in_progress_in(acq), .irq_request_out(irq_req), .irq_out(irq));
    camera_serial_model #(.BIT_CYC(16)) i_camera_serial_model (.clk_in(clk_in),
        .line_in(ser_o), .line_out(ser_i), .got_out(got));
    // =========================================================
    // helpers
    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function logic [7:0] fv_status(input logic en); // pending, gated and summary bits
        return en ? 8'hd0 : 8'h40;
    endfunction : fv_status
    task test_done;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 d = rdat; // data stands only in this cycle
    endtask : rd
    task cs(input logic [7:0] e); // status read and compare
        rd(camera_uart_pkg::OFS_STATUS, v);
        chk("status", e, v);
    endtask : cs
    // hang guard: whole run is under two thousand cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done;
        end
    end
    // =========================================================
    // main sequence
    initial begin
        b = 8'h31;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        cs(8'h00);
        wr(camera_uart_pkg::OFS_EVMASK, 8'h04);
        wr(camera_uart_pkg::OFS_CONTROL, 8'h10);
        for (int m = 0; m < 6; m++) begin
            pol = m[0];
            sel = (m >= 4) ? 2 : m[1];
            pins <= {3{~pol}};
            wr(camera_uart_pkg::OFS_UTIL3, {4'h0, m[1], pol, 2'b00});
            wr(camera_uart_pkg::OFS_UTIL2, {3'h0, m >= 4, pol, 3'h0});
            repeat (6) @(posedge clk_in);
            wr(camera_uart_pkg::OFS_COMMAND, 8'h10);
            pins <= {3{pol}} ^ (3'b001 << sel); // unselected sources only
            repeat (6) @(posedge clk_in);
            cs(8'h00);
            pins[sel] <= pol;
            repeat (6) @(posedge clk_in);
            cs(fv_status(pol));
            chk("irq_req", {7'h0, pol}, {7'h0, irq_req});
            chk("host_irq", {7'h0, pol}, {7'h0, host_irq});
        end
        chk("irq", 8'h01, {7'h0, irq});
        rd(camera_uart_pkg::OFS_EVENTS, v);
        chk("events", 8'h04, v);
        chk("irq", 8'h00, {7'h0, irq});
        wr(camera_uart_pkg::OFS_STATUS, 8'hff);
        cs(8'hd0);
        rd(8'h7f, v);
        chk("unmapped", 8'h00, v);
        wr(camera_uart_pkg::OFS_COMMAND, 8'h10);
        wr(camera_uart_pkg::OFS_CONFIG, 8'h80);
        acq <= 1'b1;
        repeat (6) @(posedge clk_in);
        cs(8'ha0);
        acq <= 1'b0;
        wr(camera_uart_pkg::OFS_UTIL2, 8'h00);
        repeat (6) @(posedge clk_in);
        cs(8'ha0);
        wr(camera_uart_pkg::OFS_COMMAND, 8'h04);
        cs(8'h00);
        wr(camera_uart_pkg::OFS_CONTROL, 8'h1b);
        cs(8'h82);
        for (int k = 0; k < 4; k++) begin
            b = lfsr(b);
            wr(camera_uart_pkg::OFS_CHAR, b);
            cs(8'h00);
            repeat (176) @(posedge clk_in);
            chk("tx byte", b, got);
            b = lfsr(b);
            i_camera_serial_model.send(b);
            repeat (8) @(posedge clk_in);
            cs(8'h83);
            rd(camera_uart_pkg::OFS_CHAR, v);
            chk("rx byte", b, v);
            wr(camera_uart_pkg::OFS_CONTROL, 8'h3b);
            cs(8'h82);
        end
        test_done;
    end
endmodule : camera_uart_irq_status_bench

//--- verilog/camera_uart_irq_status.sv
// camera serial port with the interface interrupt status register
//
// Overview of operation
// - 8 data bits, one stop, no parity
// - write when tx ready sends the byte
// - char read returns last received character
// - tx ready set when enabled and idle
// - rx ready held until control bit 5
// - status bit 7 ORs four interrupt terms
// - interface term ANDed with global enable
// - frame-valid pending held until command bit 4
// - acquisition flag on enabled acquire rising edge
// - acquisition flag held until command bit 2
// - status bit 4 is pending AND enable
// - default source is frame-valid edge
// - expose select picks expose signal edge
// - opto select picks optocoupler edge
// - status register read-only, hardware-changed
// - baud select picks four line rates
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module camera_uart_irq_status #(
    parameter int BIT_CYC_0 = camera_uart_pkg::BIT_CYC_0, // cycles per bit, 9600
    parameter int BIT_CYC_1 = camera_uart_pkg::BIT_CYC_1, // cycles per bit, 19200
    parameter int BIT_CYC_2 = camera_uart_pkg::BIT_CYC_2, // cycles per bit, 38400
    parameter int BIT_CYC_3 = camera_uart_pkg::BIT_CYC_3  // cycles per bit, 115200
) (
    input wire logic clk_in,                 // 125 MHz system clock
    input wire logic rst_in,                 // async reset, active high
    input wire logic [7:0] addr_in,          // register address
    input wire logic [7:0] wr_data_in,       // write data
    input wire logic wr_in,                  // write strobe
    input wire logic rd_in,                  // read strobe
    output logic [7:0] rd_data_out,          // read data, cycle after strobe
    input wire logic serial_in_from_camera,  // camera serial line in
    output logic serial_out_to_camera,       // camera serial line out
    input wire logic frame_valid_in,         // camera frame-valid
    input wire logic expose_in,              // expose from shutter timer
    input wire logic opto_trigger_in,        // optocoupler trigger
    input wire logic acquire_in_progress_in, // acquire-in-progress status
    output logic irq_request_out,            // interface irq to bus bridge
    output logic irq_out                     // sticky event irq through the event mask
);
    // =========================================================
    // input synchronisers
    // order: 0 rx line, 1 frame-valid, 2 expose, 3 opto, 4 acquire
    logic [4:0] sync1_r;                     // first stage, read only by stage two
    logic [4:0] sync2_r;                     // stable samples
    logic [4:0] prev_r;                      // previous stable sample
    wire logic [4:0] raw_pins = {acquire_in_progress_in, opto_trigger_in, expose_in,
                                 frame_valid_in, serial_in_from_camera};

    // two flops then a history flop for edges; rx line idles high
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= 5'h01;
            sync2_r <= 5'h01;
            prev_r <= 5'h01;
        end else begin
            sync1_r <= raw_pins;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    wire logic [4:0] rise = sync2_r & ~prev_r;
    wire logic [4:0] fall = ~sync2_r & prev_r;

    // =========================================================
    // configuration registers
    logic [7:0] ctrl_r;                      // serial control, bit 5 reads zero
    logic acq_en_r;                          // acquisition irq enable
    logic pol_r;                             // edge_polarity_select
    logic expose_sel_r;                      // expose_source_select
    logic opto_sel_r;                        // opto_source_select
    logic fv_en_r;                           // frame_valid_irq_enable
    logic [camera_uart_pkg::EV_WIDTH-1:0] evmask_r; // event mask

    wire logic wr_cmd = wr_in && addr_in == camera_uart_pkg::OFS_COMMAND;
    wire logic wr_char = wr_in && addr_in == camera_uart_pkg::OFS_CHAR;
    wire logic wr_ctl = wr_in && addr_in == camera_uart_pkg::OFS_CONTROL;
    wire logic rx_ready_clear = wr_ctl && wr_data_in[camera_uart_pkg::CTL_RX_CLR];
    wire logic acquisition_irq_clear = wr_cmd && wr_data_in[camera_uart_pkg::CMD_ACQ_CLR];
    wire logic frame_valid_irq_clear = wr_cmd && wr_data_in[camera_uart_pkg::CMD_FV_CLR];

    // stored control bits; the clear bit is a pulse, never stored
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= camera_uart_pkg::CTRL_RESET;
            acq_en_r <= 1'b0;
            pol_r <= 1'b0;
            expose_sel_r <= 1'b0;
            opto_sel_r <= 1'b0;
            fv_en_r <= 1'b0;
            evmask_r <= camera_uart_pkg::EVMASK_RESET;
        end else if (wr_in) begin
            unique case (addr_in)
                camera_uart_pkg::OFS_CONTROL: begin
                    ctrl_r <= wr_data_in & ~(8'h01 << camera_uart_pkg::CTL_RX_CLR);
                end
                camera_uart_pkg::OFS_CONFIG: acq_en_r <= wr_data_in[camera_uart_pkg::CFG_ACQ_EN];
                camera_uart_pkg::OFS_UTIL3: begin
                    pol_r <= wr_data_in[camera_uart_pkg::U3_POL];
                    expose_sel_r <= wr_data_in[camera_uart_pkg::U3_EXPOSE];
                end
                camera_uart_pkg::OFS_UTIL2: begin
                    fv_en_r <= wr_data_in[camera_uart_pkg::U2_FV_EN];
                    opto_sel_r <= wr_data_in[camera_uart_pkg::U2_OPTO];
                end
                camera_uart_pkg::OFS_EVMASK: begin
                    evmask_r <= wr_data_in[camera_uart_pkg::EV_WIDTH-1:0];
                end
                default: ;                   // other offsets hold no stored bits here
            endcase
        end
    end

    wire logic rx_en = ctrl_r[camera_uart_pkg::CTL_RX_EN];
    wire logic tx_en = ctrl_r[camera_uart_pkg::CTL_TX_EN];
    wire logic global_irq_enable = ctrl_r[camera_uart_pkg::CTL_GLOB_IE];

    // baud select to cycles per bit
    logic [15:0] bit_cyc;
    always_comb begin
        unique case (ctrl_r[camera_uart_pkg::CTL_BAUD_LO +: 2])
            2'b00: bit_cyc = 16'(BIT_CYC_0);
            2'b01: bit_cyc = 16'(BIT_CYC_1);
            2'b10: bit_cyc = 16'(BIT_CYC_2);
            2'b11: bit_cyc = 16'(BIT_CYC_3);
        endcase
    end

    // =========================================================
    // transmitter
    camera_uart_pkg::line_state_e tx_state_r; // transmit engine state
    logic [15:0] tx_cnt_r;                   // cycles left in current bit
    logic [2:0] tx_bit_r;                    // data bit index
    logic [7:0] tx_shift_r;                  // byte being sent
    logic tx_done;                           // stop bit finished

    wire logic tx_ready = tx_en && tx_state_r == camera_uart_pkg::LN_IDLE;
    wire logic tx_accept = wr_char && tx_ready;
    assign tx_done = tx_state_r == camera_uart_pkg::LN_STOP && tx_cnt_r == 16'h0001;

    // start low, lsb first, one stop, line idles high; writes while busy are dropped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_state_r <= camera_uart_pkg::LN_IDLE;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 3'h0;
            tx_shift_r <= 8'h00;
            serial_out_to_camera <= 1'b1;
        end else begin
            unique case (tx_state_r)
                camera_uart_pkg::LN_IDLE: begin
                    if (tx_accept) begin
                        tx_shift_r <= wr_data_in;
                        tx_cnt_r <= bit_cyc;
                        serial_out_to_camera <= 1'b0;
                        tx_state_r <= camera_uart_pkg::LN_START;
                    end
                end
                camera_uart_pkg::LN_START, camera_uart_pkg::LN_DATA: begin
                    if (tx_cnt_r == 16'h0001) begin
                        tx_cnt_r <= bit_cyc;
                        serial_out_to_camera <= tx_shift_r[0];
                        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
                        if (tx_state_r == camera_uart_pkg::LN_START) begin
                            tx_bit_r <= 3'h0;
                            tx_state_r <= camera_uart_pkg::LN_DATA;
                        end else if (tx_bit_r == 3'(camera_uart_pkg::DATA_BITS - 1)) begin
                            serial_out_to_camera <= 1'b1;
                            tx_state_r <= camera_uart_pkg::LN_STOP;
                        end else begin
                            tx_bit_r <= tx_bit_r + 3'h1;
                        end
                    end else begin
                        tx_cnt_r <= tx_cnt_r - 16'h0001;
                    end
                end
                camera_uart_pkg::LN_STOP: begin
                    if (tx_done) begin
                        tx_state_r <= camera_uart_pkg::LN_IDLE;
                    end else begin
                        tx_cnt_r <= tx_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // receiver
    camera_uart_pkg::line_state_e rx_state_r; // receive engine state
    logic [15:0] rx_cnt_r;                   // cycles to next sample
    logic [2:0] rx_bit_r;                    // data bit index
    logic [7:0] rx_shift_r;                  // assembling byte
    logic [7:0] rx_char_r;                   // last received character
    logic rx_ready_r;                        // receive-ready flag
    logic rx_got;                            // good stop bit seen
    logic rx_bad;                            // stop bit low
    wire logic rx_line = sync2_r[0];

    assign rx_got = rx_state_r == camera_uart_pkg::LN_STOP && rx_cnt_r == 16'h0001 && rx_line;
    assign rx_bad = rx_state_r == camera_uart_pkg::LN_STOP && rx_cnt_r == 16'h0001 && !rx_line;

    // sample mid-bit; a start glitch shorter than half a bit is ignored
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_state_r <= camera_uart_pkg::LN_IDLE;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 3'h0;
            rx_shift_r <= 8'h00;
            rx_char_r <= 8'h00;
        end else begin
            unique case (rx_state_r)
                camera_uart_pkg::LN_IDLE: begin
                    if (rx_en && !rx_line) begin
                        rx_cnt_r <= bit_cyc >> 1;
                        rx_state_r <= camera_uart_pkg::LN_START;
                    end
                end
                camera_uart_pkg::LN_START: begin
                    if (rx_cnt_r == 16'h0001) begin
                        rx_cnt_r <= bit_cyc;
                        rx_bit_r <= 3'h0;
                        rx_state_r <= rx_line ? camera_uart_pkg::LN_IDLE
                                              : camera_uart_pkg::LN_DATA;
                    end else begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end
                end
                camera_uart_pkg::LN_DATA: begin
                    if (rx_cnt_r == 16'h0001) begin
                        rx_cnt_r <= bit_cyc;
                        rx_shift_r <= {rx_line, rx_shift_r[7:1]};
                        if (rx_bit_r == 3'(camera_uart_pkg::DATA_BITS - 1)) begin
                            rx_state_r <= camera_uart_pkg::LN_STOP;
                        end else begin
                            rx_bit_r <= rx_bit_r + 3'h1;
                        end
                    end else begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end
                end
                camera_uart_pkg::LN_STOP: begin
                    if (rx_cnt_r == 16'h0001) begin
                        if (rx_line) begin
                            rx_char_r <= rx_shift_r;
                        end
                        rx_state_r <= camera_uart_pkg::LN_IDLE;
                    end else begin
                        rx_cnt_r <= rx_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    // receive-ready: a new character wins over a clear in the same cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_ready_r <= 1'b0;
        end else if (rx_got && rx_en) begin
            rx_ready_r <= 1'b1;
        end else if (rx_ready_clear) begin
            rx_ready_r <= 1'b0;
        end
    end

    // =========================================================
    // frame-valid and acquisition interrupt flags
    logic fv_pend_r;                         // frame_valid_irq_pending
    logic acq_flag_r;                        // acquisition_irq_flag
    logic fv_event;                          // selected source edge

    // opto overrides expose, expose overrides frame-valid
    always_comb begin
        if (opto_sel_r) begin
            fv_event = pol_r ? rise[3] : fall[3];
        end else if (expose_sel_r) begin
            fv_event = pol_r ? rise[2] : fall[2];
        end else begin
            fv_event = pol_r ? rise[1] : fall[1];
        end
    end

    wire logic acq_event = acq_en_r && rise[4];

    // sticky flags; a new event beats its clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fv_pend_r <= 1'b0;
            acq_flag_r <= 1'b0;
        end else begin
            fv_pend_r <= fv_event || (fv_pend_r && !frame_valid_irq_clear);
            acq_flag_r <= acq_event || (acq_flag_r && !acquisition_irq_clear);
        end
    end

    wire logic frame_valid_irq_gated = fv_pend_r && fv_en_r;
    wire logic interface_irq_flag = (tx_ready && ctrl_r[camera_uart_pkg::CTL_TX_IE])
        || (rx_ready_r && ctrl_r[camera_uart_pkg::CTL_RX_IE]) || acq_flag_r
        || frame_valid_irq_gated;
    wire logic [7:0] status = {interface_irq_flag, fv_pend_r, acq_flag_r,
        frame_valid_irq_gated, 2'b00, tx_ready, rx_ready_r};

    // bridge applies its own two enables downstream
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_request_out <= 1'b0;
        end else begin
            irq_request_out <= interface_irq_flag && global_irq_enable;
        end
    end

    // =========================================================
    // sticky events, read of the event register clears them
    logic [camera_uart_pkg::EV_WIDTH-1:0] events_r; // sticky event bits
    wire logic [camera_uart_pkg::EV_WIDTH-1:0] ev_in = {rx_bad, acq_event, fv_event,
                                                        tx_done, rx_got};
    wire logic ev_read = rd_in && addr_in == camera_uart_pkg::OFS_EVENTS;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            events_r <= '0;
            irq_out <= 1'b0;
        end else begin
            events_r <= ev_in | (ev_read ? '0 : events_r);
            irq_out <= |((ev_in | (ev_read ? '0 : events_r)) & evmask_r);
        end
    end

    // =========================================================
    // read port, data one cycle after strobe, unmapped reads zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                camera_uart_pkg::OFS_CHAR: rd_data_out <= rx_char_r;
                camera_uart_pkg::OFS_STATUS: rd_data_out <= status;
                camera_uart_pkg::OFS_CONTROL: rd_data_out <= ctrl_r;
                camera_uart_pkg::OFS_CONFIG: rd_data_out <= {acq_en_r, 7'h00};
                camera_uart_pkg::OFS_UTIL3: rd_data_out <= {4'h0, expose_sel_r, pol_r, 2'b00};
                camera_uart_pkg::OFS_UTIL2: rd_data_out <= {3'h0, opto_sel_r, fv_en_r, 3'h0};
                camera_uart_pkg::OFS_EVENTS: rd_data_out <= 8'(events_r);
                camera_uart_pkg::OFS_EVMASK: rd_data_out <= 8'(evmask_r);
                default: rd_data_out <= 8'h00;
            endcase
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // =========================================================
    // assertions
    a_tx_busy_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_accept |=> !tx_ready ##1 !tx_ready)
        else $error("tx ready not dropped after accept");
    a_tx_start_low: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_accept |=> !serial_out_to_camera && tx_shift_r == $past(wr_data_in))
        else $error("accepted byte not started");
    a_tx_idle_high: assert property (@(posedge clk_in) disable iff (rst_in)
        tx_state_r == camera_uart_pkg::LN_IDLE |-> serial_out_to_camera)
        else $error("line not high while idle");
    a_rx_hold_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        rx_ready_r && !rx_ready_clear |=> rx_ready_r)
        else $error("rx ready lost without clear");
    a_char_read_data: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_in && addr_in == camera_uart_pkg::OFS_CHAR
            |=> rd_data_out == $past(rx_char_r))
        else $error("char read wrong data");
    a_irq_req_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        !global_irq_enable |=> !irq_request_out)
        else $error("irq request without global enable");
    a_acq_flag_set: assert property (@(posedge clk_in) disable iff (rst_in)
        acq_en_r && rise[4] |=> acq_flag_r ##1 (acq_flag_r || $past(acquisition_irq_clear)))
        else $error("acquisition flag not set");
    a_acq_flag_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        acq_flag_r && !acquisition_irq_clear |=> acq_flag_r)
        else $error("acquisition flag lost");
    a_fv_pend_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        fv_pend_r && !frame_valid_irq_clear |=> fv_pend_r)
        else $error("frame-valid pending lost");
    a_status_gated: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_in && addr_in == camera_uart_pkg::OFS_STATUS
            |=> rd_data_out[camera_uart_pkg::ST_FV_GATED]
            == ($past(fv_pend_r) && $past(fv_en_r)))
        else $error("gated frame-valid bit wrong");
    a_opto_select: assert property (@(posedge clk_in) disable iff (rst_in)
        opto_sel_r && pol_r && rise[3] && !frame_valid_irq_clear |=> fv_pend_r)
        else $error("opto edge missed");
endmodule : camera_uart_irq_status
